// ===== hdl/fsp_defs.svh
// Purpose: Constants for the flash self-programming sequencer
// Assumes: Included by its bare name; definitions only
// Notes:   Word addresses are flash word addresses, not byte addresses
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// ==========================================================
// Flash geometry
`define FSP_PC_W 12
`define FSP_PAGE_WORDS 64
`define FSP_WORD_SEL_W 5
`define FSP_PAGE_SEL_W 7
`define FSP_Z_PAGE_LSB 6
`define FSP_Z_PAGE_MSB 12
`define FSP_Z_WORD_LSB 1
`define FSP_Z_WORD_MSB 5
`define FSP_STALL_REGION_START 12'hC00
`define FSP_STALL_REGION_PAGE 7'h60

// ==========================================================
// Boot section start per boot size fuse code
`define FSP_BOOT_START_11 12'hF80
`define FSP_BOOT_START_10 12'hF00
`define FSP_BOOT_START_01 12'hE00
`define FSP_BOOT_START_00 12'hC00

// ==========================================================
// Register byte offsets
`define FSP_OFS_CTRL 4'h0
`define FSP_OFS_STATUS 4'h4

// ==========================================================
// Control register bit positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REENABLE 4
`define FSP_BIT_BUSY 6
`define FSP_CTRL_RESET 5'h00

// ==========================================================
// Timing
`define FSP_SPM_WINDOW 3'h4
`define FSP_LPM_WINDOW 3'h3
`define FSP_PROG_MIN_US 3700
`define FSP_REF_CLK_MHZ 125

`endif

// ===== hdl/fsp_pkg.sv
// Purpose: Types shared by the flash self-programming sequencer
// Assumes: Constants live in fsp_defs.svh
// Notes:   None
package fsp_pkg;
    // ==========================================================
    // Sequencer state
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_PROG
    } fsp_state_t;

    // Flash word and data types
    typedef logic [11:0] fsp_addr_t;
    typedef logic [15:0] fsp_word_t;
endpackage

// ===== hdl/fsp_page_buf.sv
// Purpose: Temporary page buffer, one flash page of words
// Assumes: Single clock, one write and one read port
// Notes:   Read data comes out of a register one cycle after the address
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_page_buf (
    // Clock
    input wire logic ref_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [`FSP_WORD_SEL_W-1:0] wr_addr,
    input wire fsp_pkg::fsp_word_t wr_data,
    // Read port
    input wire logic [`FSP_WORD_SEL_W-1:0] rd_addr,
    output fsp_pkg::fsp_word_t rd_data
);
    import fsp_pkg::*;

    // Storage, no reset so it maps onto a RAM
    fsp_word_t mem [0:(1<<`FSP_WORD_SEL_W)-1];

    // ==========================================================
    // Write
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ==========================================================
    // Registered read
    always_ff @(posedge ref_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== hdl/fsp_sequencer.sv
// Purpose: Flash self-programming sequencer: sections, Z mapping, command control
// Assumes: CPU strobes come from logic on ref_clk; fuse pins are asynchronous
// Notes:   Flash array timing is modelled by a programming counter
// Behaviour
// - Boot fuse code picks boot section start
// - Concurrent region below 0xC00, stalling above
// - Block concurrent-region fetch during erase/write
// - Program counter is twelve bits wide
// - Page word selected by PC bits 4:0
// - Erase/write page from Z bits 12:6
// - Buffer word from Z bits 5:1
// - Z bits 15:13 always ignored
// - Z bit 0 selects LPM byte
// - Busy flag cleared only by reenable command
// - Decode erase, write and buffer load commands
// - Command bits auto-clear after missed window
// - Busy flag held while region is busy
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_sequencer #(
    parameter int PROG_CYCLES = `FSP_PROG_MIN_US * `FSP_REF_CLK_MHZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU core strobes
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] z_ptr,
    input wire fsp_pkg::fsp_word_t spm_data,
    input wire fsp_pkg::fsp_addr_t fetch_pc,
    input wire logic eeprom_write_in_progress,
    // Fuse pins
    input wire logic boot_size_fuse_hi,
    input wire logic boot_size_fuse_lo,
    // CPU side results
    output logic fetch_stall,
    output logic cpu_halt,
    output logic in_boot_section,
    output fsp_pkg::fsp_addr_t boot_start,
    output fsp_pkg::fsp_addr_t lpm_word_addr,
    output logic lpm_byte_hi,
    output logic lpm_fuse_read,
    // Flash array side
    output logic flash_erase_start,
    output logic flash_write_start,
    output logic [`FSP_PAGE_SEL_W-1:0] flash_page,
    input wire logic [`FSP_WORD_SEL_W-1:0] flash_buf_addr,
    output fsp_pkg::fsp_word_t flash_buf_data
);
    import fsp_pkg::*;

    // ==========================================================
    // Declarations
    fsp_state_t state_reg; // Sequencer state
    logic [4:0] ctrl_reg; // Command bits of self_prog_control_reg
    logic concurrent_region_busy_flag; // Sticky busy flag
    logic [2:0] window_reg; // Cycles left to issue SPM or LPM
    logic [18:0] prog_cnt_reg; // Programming time counter
    logic op_rww_reg; // Running op targets concurrent region
    logic [1:0] fuse_meta_reg; // First synchroniser stage
    logic [1:0] fuse_sync_reg; // Second synchroniser stage
    logic ack_reg; // Bus answer phase
    logic bus_req; // Request present
    logic bus_wr_ok; // Write taken this edge
    logic ctrl_wr; // Control write accepted
    logic [`FSP_PAGE_SEL_W-1:0] z_page; // Page select field
    logic [`FSP_WORD_SEL_W-1:0] z_word; // Word select field
    logic spm_in_window; // SPM arrived in time
    logic buf_load; // Page buffer write strobe
    logic op_start; // Erase or write begins
    logic prog_done; // Programming time elapsed
    fsp_addr_t boot_start_next; // Decoded boot start

    // ==========================================================
    // Z pointer mapping; bits 15:13 never reach any decoder
    assign z_page = z_ptr[`FSP_Z_PAGE_MSB:`FSP_Z_PAGE_LSB];
    assign z_word = z_ptr[`FSP_Z_WORD_MSB:`FSP_Z_WORD_LSB];

    // ==========================================================
    // Fuse synchroniser, pins are not on ref_clk
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fuse_meta_reg <= 2'h3;
            fuse_sync_reg <= 2'h3;
        end else begin
            fuse_meta_reg <= {boot_size_fuse_hi, boot_size_fuse_lo};
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // ==========================================================
    // Boot section decode
    always_comb begin
        unique case (fuse_sync_reg)
            2'h3: boot_start_next = `FSP_BOOT_START_11; // 128 words
            2'h2: boot_start_next = `FSP_BOOT_START_10; // 256 words
            2'h1: boot_start_next = `FSP_BOOT_START_01; // 512 words
            2'h0: boot_start_next = `FSP_BOOT_START_00; // 1024 words
        endcase
    end

    // Registered so boot_start is a clean data output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            boot_start <= `FSP_BOOT_START_11;
            in_boot_section <= 1'b0;
        end else begin
            boot_start <= boot_start_next;
            // Application section ends one word below boot start
            in_boot_section <= (fetch_pc >= boot_start_next);
        end
    end

    // ==========================================================
    // Avalon slave: one wait cycle, answer on the second cycle
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign bus_wr_ok = avs_write & ack_reg;

    // Control writes are dropped while an EEPROM write, a running
    // operation or an armed command is in progress
    assign ctrl_wr = bus_wr_ok && (avs_address == `FSP_OFS_CTRL) && !eeprom_write_in_progress
                     && (state_reg == FSP_IDLE);

    // Answer phase flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // Read data captured in the wait cycle; unmapped reads as zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= 32'h0000_0000;
            if (avs_address == `FSP_OFS_CTRL) begin
                avs_readdata[4:0] <= ctrl_reg;
                avs_readdata[`FSP_BIT_BUSY] <= concurrent_region_busy_flag;
            end else if (avs_address == `FSP_OFS_STATUS) begin
                avs_readdata[11:0] <= boot_start;
                avs_readdata[13:12] <= fuse_sync_reg;
                avs_readdata[16] <= (state_reg == FSP_PROG);
            end
        end
    end

    // ==========================================================
    // Command window and decode
    assign spm_in_window = spm_exec && (state_reg == FSP_ARMED) && (window_reg != 3'h0);
    // Enable bit alone loads r0 into the buffer
    assign buf_load = spm_in_window && (ctrl_reg[4:1] == 4'h0);
    // Erase or write needs its own bit with the enable bit
    assign op_start = spm_in_window && (ctrl_reg[`FSP_BIT_ERASE] || ctrl_reg[`FSP_BIT_WRITE]);
    assign prog_done = (state_reg == FSP_PROG) && (prog_cnt_reg == 19'h0_0001);

    // Sequencer state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= FSP_IDLE;
        end else begin
            unique case (state_reg)
                FSP_IDLE: begin
                    if (ctrl_wr && avs_writedata[`FSP_BIT_ENABLE]) begin
                        state_reg <= FSP_ARMED;
                    end
                end
                FSP_ARMED: begin
                    if (op_start) begin
                        state_reg <= FSP_PROG;
                    end else if (spm_in_window || window_reg == 3'h0) begin
                        state_reg <= FSP_IDLE; // Done, or window missed
                    end else if (lpm_exec && ctrl_reg[`FSP_BIT_LOCK] && window_reg > 3'h1) begin
                        state_reg <= FSP_IDLE; // Lock or fuse read consumed
                    end
                end
                FSP_PROG: begin
                    if (prog_done) begin
                        state_reg <= FSP_IDLE;
                    end
                end
                default: state_reg <= FSP_IDLE;
            endcase
        end
    end

    // Window counter; LPM window is one cycle shorter than SPM
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            window_reg <= 3'h0;
        end else if (ctrl_wr && avs_writedata[`FSP_BIT_ENABLE]) begin
            window_reg <= `FSP_SPM_WINDOW;
        end else if (window_reg != 3'h0) begin
            window_reg <= window_reg - 3'h1;
        end
    end

    // ==========================================================
    // Control register command bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `FSP_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= avs_writedata[4:0];
            if (!avs_writedata[`FSP_BIT_ENABLE]) begin
                ctrl_reg <= `FSP_CTRL_RESET; // Nothing to arm without enable
            end
        end else if (state_reg == FSP_ARMED && !op_start) begin
            if (spm_in_window) begin
                ctrl_reg <= `FSP_CTRL_RESET; // Buffer load or reenable done
            end else if (window_reg == 3'h0) begin
                ctrl_reg <= `FSP_CTRL_RESET;
            end else if (lpm_exec && ctrl_reg[`FSP_BIT_LOCK] && window_reg > 3'h1) begin
                ctrl_reg <= `FSP_CTRL_RESET;
            end
        end else if (prog_done) begin
            ctrl_reg <= `FSP_CTRL_RESET; // Enable bit clears on completion
        end
    end

    // Lock and fuse read strobe, one cycle after an LPM that arrives inside its window
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lpm_fuse_read <= 1'b0;
        end else begin
            lpm_fuse_read <= lpm_exec && (state_reg == FSP_ARMED) && ctrl_reg[`FSP_BIT_LOCK]
                             && (window_reg > 3'h1);
        end
    end

    // ==========================================================
    // Programming timer and target region
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prog_cnt_reg <= 19'h0_0000;
            op_rww_reg <= 1'b0;
        end else if (op_start) begin
            prog_cnt_reg <= PROG_CYCLES[18:0];
            op_rww_reg <= (z_page < `FSP_STALL_REGION_PAGE);
        end else if (state_reg == FSP_PROG) begin
            prog_cnt_reg <= prog_cnt_reg - 19'h0_0001;
        end
    end

    // Flash start pulses and page latch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
            flash_page <= 7'h00;
        end else begin
            flash_erase_start <= op_start && ctrl_reg[`FSP_BIT_ERASE];
            flash_write_start <= op_start && !ctrl_reg[`FSP_BIT_ERASE];
            if (op_start) begin
                flash_page <= z_page;
            end
        end
    end

    // ==========================================================
    // Busy flag: set when a concurrent-region op starts, stays set
    // after it ends until the reenable command; the set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            concurrent_region_busy_flag <= 1'b0;
        end else if (op_start && z_page < `FSP_STALL_REGION_PAGE) begin
            concurrent_region_busy_flag <= 1'b1;
        end else if (spm_in_window && ctrl_reg[`FSP_BIT_REENABLE]) begin
            concurrent_region_busy_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Fetch control: concurrent region unreadable during its op,
    // whole CPU halted when the stalling region itself is programmed
    always_comb begin
        fetch_stall = 1'b0;
        cpu_halt = 1'b0;
        if (state_reg == FSP_PROG) begin
            if (op_rww_reg) begin
                fetch_stall = (fetch_pc < `FSP_STALL_REGION_START);
            end else begin
                cpu_halt = 1'b1;
            end
        end
    end

    // LPM addressing: word from Z bits 12:1, byte from bit 0
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lpm_word_addr <= 12'h000;
            lpm_byte_hi <= 1'b0;
        end else if (lpm_exec) begin
            lpm_word_addr <= z_ptr[`FSP_Z_PAGE_MSB:`FSP_Z_WORD_LSB];
            lpm_byte_hi <= z_ptr[0];
        end
    end

    // ==========================================================
    // Temporary page buffer
    fsp_page_buf u_page_buf (
        .ref_clk(ref_clk),
        .wr_en(buf_load),
        .wr_addr(z_word),
        .wr_data(spm_data),
        .rd_addr(flash_buf_addr),
        .rd_data(flash_buf_data)
    );
endmodule

// ===== dv/fsp_sequencer_monitor.sv
// Purpose: Port-level checks on the flash self-programming sequencer
// Assumes: One clock; rst_n synchronous, active low
// Notes: Bound to fsp_sequencer from the bench top file
`timescale 1ns/1ns
`include "fsp_defs.svh"
module fsp_sequencer_monitor #(
    parameter int PROG_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // CPU strobes and fuses
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] z_ptr,
    input wire fsp_pkg::fsp_addr_t fetch_pc,
    input wire logic boot_size_fuse_hi,
    input wire logic boot_size_fuse_lo,
    // Results
    input wire logic fetch_stall,
    input wire logic cpu_halt,
    input wire logic in_boot_section,
    input wire fsp_pkg::fsp_addr_t boot_start,
    input wire fsp_pkg::fsp_addr_t lpm_word_addr,
    input wire logic lpm_byte_hi,
    input wire logic flash_erase_start,
    input wire logic flash_write_start,
    input wire logic [`FSP_PAGE_SEL_W-1:0] flash_page
);
    import fsp_pkg::*;
    // ==========================================================
    // Helper logic
    logic [1:0] fuse; // Raw fuse code
    fsp_addr_t start_exp; // Boot start the fuse code asks for
    logic [2:0] up_cnt; // Cycles since reset release
    int halt_cnt; // Length of the current halt
    assign fuse = {boot_size_fuse_hi, boot_size_fuse_lo};
    assign start_exp = fuse == 2'b11 ? `FSP_BOOT_START_11 : fuse == 2'b10 ? `FSP_BOOT_START_10 :
        fuse == 2'b01 ? `FSP_BOOT_START_01 : `FSP_BOOT_START_00;
    // Saturating count; the fuse synchroniser needs three edges to settle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    // Halt length counter, cleared whenever the core runs
    always_ff @(posedge ref_clk) begin
        halt_cnt <= (rst_n && cpu_halt) ? halt_cnt + 1 : 0;
    end
    default clocking mon_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Assertions
    boot_map_a:
        assert property (up_cnt >= 3'h4 && fuse == $past(fuse) && fuse == $past(fuse, 2) && fuse == $past(fuse, 3)
            |-> boot_start == start_exp) else $error("boot start differs from fuse code");
    boot_flag_a:
        assert property (up_cnt >= 3'h4 && $stable(boot_start) |-> in_boot_section == ($past(fetch_pc) >= boot_start))
            else $error("boot section flag wrong");
    wait_cycle_a:
        assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
            else $error("bus answer not after one wait cycle");
    stall_region_a:
        assert property (fetch_stall |-> fetch_pc < 12'hC00 && flash_page < `FSP_STALL_REGION_PAGE && !cpu_halt)
            else $error("fetch stall outside concurrent region");
    halt_region_a:
        assert property (cpu_halt |-> flash_page >= `FSP_STALL_REGION_PAGE) else $error("halt for concurrent page");
    halt_len_a:
        assert property (halt_cnt <= PROG_CYCLES + 2) else $error("halt lasts too long");
    start_cause_a:
        assert property (flash_erase_start || flash_write_start |-> $past(spm_exec) && flash_page == $past(z_ptr[12:6]))
            else $error("start without store command or wrong page");
    start_one_a:
        assert property (!(flash_erase_start && flash_write_start)) else $error("erase and write started together");
    lpm_addr_a:
        assert property ($past(lpm_exec) |-> lpm_word_addr == $past(z_ptr[12:1]) && lpm_byte_hi == $past(z_ptr[0]))
            else $error("load address or byte select wrong");
endmodule

// ===== dv/fsp_cpu_model.sv
// Purpose: CPU core running boot code, as seen by the sequencer
// Assumes: Driven by the bench through the issue task
// Notes: Interrupts are never taken, so timed sequences stay intact
`timescale 1ns/1ns
module fsp_cpu_model (
    // Clock
    input wire logic ref_clk,
    // Strobes to the sequencer
    output logic spm_exec = 1'b0,
    output logic lpm_exec = 1'b0,
    output logic [15:0] z_ptr = 16'h0000,
    output fsp_pkg::fsp_word_t spm_data = 16'h0000
);
    import fsp_pkg::*;
    // One store or load instruction, strobe held one cycle
    task automatic issue(input logic lpm, input logic [15:0] z, input fsp_word_t d);
        @(posedge ref_clk);
        z_ptr <= lpm ? z : {z[15:1], 1'b0}; // Store commands keep Z bit 0 low
        spm_data <= d;
        spm_exec <= !lpm;
        lpm_exec <= lpm;
        @(posedge ref_clk);
        spm_exec <= 1'b0;
        lpm_exec <= 1'b0;
        // Operands are unqualified now, so show something else
        z_ptr <= ~z_ptr;
        spm_data <= ~spm_data;
    endtask
endmodule

// ===== dv/fsp_sequencer_tb.sv
// Purpose: Self-checking bench for the flash self-programming sequencer
// Assumes: Programming time shortened through PROG_CYCLES
// Notes: CPU strobes come from fsp_cpu_model
`timescale 1ns/1ns
`include "fsp_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", n, e, g); err_count++; end end
module fsp_sequencer_tb;
    import fsp_pkg::*;
    // ==========================================================
    // Signals
    localparam int PROG_CYCLES = 20;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic eeprom_write_in_progress = 1'b0;
    logic boot_size_fuse_hi = 1'b1;
    logic boot_size_fuse_lo = 1'b1;
    fsp_addr_t fetch_pc = 12'h000;
    logic [4:0] flash_buf_addr = 5'h00;
    logic spm_exec, lpm_exec, avs_waitrequest, fetch_stall, cpu_halt, in_boot_section;
    logic lpm_byte_hi, lpm_fuse_read, flash_erase_start, flash_write_start, last_erase, saw_stall, saw_halt;
    logic [15:0] z_ptr;
    fsp_word_t spm_data, flash_buf_data;
    fsp_addr_t boot_start, lpm_word_addr;
    logic [6:0] flash_page, last_page;
    int cycles = 0, n_starts = 0, n_fuse = 0, err_count = 0, n_tests = 0, s0;
    // Fuse code beside the boot start it should give
    logic [13:0] rows [4] = '{14'h3F80, 14'h2F00, 14'h1E00, 14'h0C00};
    always #4 ref_clk = ~ref_clk;
    fsp_sequencer #(.PROG_CYCLES(PROG_CYCLES)) DUT (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .spm_exec, .lpm_exec, .z_ptr, .spm_data, .fetch_pc,
        .eeprom_write_in_progress, .boot_size_fuse_hi, .boot_size_fuse_lo, .fetch_stall, .cpu_halt,
        .in_boot_section, .boot_start, .lpm_word_addr, .lpm_byte_hi, .lpm_fuse_read, .flash_erase_start,
        .flash_write_start, .flash_page, .flash_buf_addr, .flash_buf_data);
    fsp_cpu_model cpu (.ref_clk, .spm_exec, .lpm_exec, .z_ptr, .spm_data);
    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One Avalon transfer; read data lands in q
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Wait for the enable bit to drop; bounded so a stuck bit cannot hang
    task automatic poll();
        q = 32'h1;
        for (int k = 0; k < 60 && q[0] !== 1'b0; k++) bus(1'b0, `FSP_OFS_CTRL, 32'h0);
    endtask
    task automatic cmd(input logic [31:0] v);
        poll();
        while (eeprom_write_in_progress) @(posedge ref_clk);
        bus(1'b1, `FSP_OFS_CTRL, v);
    endtask
    // ==========================================================
    // Event capture and timeout
    always @(posedge ref_clk) begin
        cycles++;
        if (flash_erase_start || flash_write_start) begin
            n_starts++;
            last_page = flash_page;
            last_erase = flash_erase_start;
        end
        if (lpm_fuse_read) n_fuse++;
        if (fetch_stall) saw_stall = 1'b1;
        if (cpu_halt) saw_halt = 1'b1;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("reset boot_start", 12'hF80, boot_start)
        `CHK("reset start", 1'b0, flash_erase_start)
        @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            {boot_size_fuse_hi, boot_size_fuse_lo} <= rows[i][13:12];
            fetch_pc <= rows[i][11:0];
            repeat (5) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("boot_start", rows[i][11:0], boot_start)
            `CHK("in boot", 1'b1, in_boot_section)
            @(posedge ref_clk);
            fetch_pc <= rows[i][11:0] - 12'h001;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("in application", 1'b0, in_boot_section)
            bus(1'b0, `FSP_OFS_STATUS, 32'h0);
            `CHK("status", rows[i], q[13:0])
        end
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'h8, 32'h0);
        `CHK("unmapped read", 32'h0, q)
        // Buffer loads at both ends of the word select
        for (int w = 0; w < 32; w += 31) begin
            cmd(32'h01);
            cpu.issue(1'b0, {3'b111, 7'h12, w[4:0], 1'b1}, 16'hA500 + 16'(w));
            bus(1'b0, `FSP_OFS_CTRL, 32'h0);
            `CHK("load clears ctrl", 32'h0, q)
            flash_buf_addr <= w[4:0];
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("buffer word", 16'hA500 + 16'(w), flash_buf_data)
        end
        // Erase of a concurrent page, both op bits set, second write refused
        fetch_pc <= 12'h100;
        saw_stall = 1'b0;
        s0 = n_starts;
        cmd(32'h07);
        cpu.issue(1'b0, {3'b101, 7'h05, 6'h00}, 16'h0000);
        bus(1'b1, `FSP_OFS_CTRL, 32'h05);
        bus(1'b0, `FSP_OFS_STATUS, 32'h0);
        `CHK("programming", 1'b1, q[16])
        poll();
        bus(1'b0, `FSP_OFS_CTRL, 32'h0);
        `CHK("busy after erase", 32'h40, q)
        `CHK("erase page", 7'h05, last_page)
        `CHK("erase wins", 1'b1, last_erase)
        `CHK("one start", 1, n_starts - s0)
        `CHK("fetch stalled", 1'b1, saw_stall)
        cmd(32'h11);
        cpu.issue(1'b0, 16'h0000, 16'h0000);
        bus(1'b0, `FSP_OFS_CTRL, 32'h0);
        `CHK("busy cleared", 32'h0, q)
        // Page write into the stalling region halts the core
        fetch_pc <= 12'hC40;
        saw_stall = 1'b0;
        saw_halt = 1'b0;
        cmd(32'h05);
        cpu.issue(1'b0, {3'b000, 7'h70, 6'h00}, 16'h0000);
        poll();
        bus(1'b0, `FSP_OFS_CTRL, 32'h0);
        `CHK("no busy", 32'h0, q)
        `CHK("write page", 7'h70, last_page)
        `CHK("write op", 1'b0, last_erase)
        `CHK("core halted", 1'b1, saw_halt)
        `CHK("no stall", 1'b0, saw_stall)
        // Store instruction after the window has closed
        s0 = n_starts;
        cmd(32'h05);
        repeat (6) @(posedge ref_clk);
        cpu.issue(1'b0, {3'b000, 7'h70, 6'h00}, 16'h0000);
        bus(1'b0, `FSP_OFS_CTRL, 32'h0);
        `CHK("auto clear", 32'h0, q)
        `CHK("late store", 0, n_starts - s0)
        // Lock read inside its window, then a plain load
        cmd(32'h09);
        cpu.issue(1'b1, 16'h0001, 16'h0000);
        @(negedge ref_clk);
        `CHK("lock pulse", 1'b1, lpm_fuse_read)
        @(negedge ref_clk);
        `CHK("lock read", 1, n_fuse)
        cpu.issue(1'b1, 16'hE00B, 16'h0000);
        @(negedge ref_clk);
        `CHK("load word", 12'h005, lpm_word_addr)
        `CHK("load byte", 1'b1, lpm_byte_hi)
        // Control write while the EEPROM is busy
        @(posedge ref_clk);
        eeprom_write_in_progress <= 1'b1;
        bus(1'b1, `FSP_OFS_CTRL, 32'h01);
        bus(1'b0, `FSP_OFS_CTRL, 32'h0);
        `CHK("eeprom refusal", 32'h0, q)
        eeprom_write_in_progress <= 1'b0;
        finish_test();
    end
endmodule
bind fsp_sequencer fsp_sequencer_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (.ref_clk, .rst_n, .avs_read,
    .avs_write, .avs_waitrequest, .spm_exec, .lpm_exec, .z_ptr, .fetch_pc, .boot_size_fuse_hi,
    .boot_size_fuse_lo, .fetch_stall, .cpu_halt, .in_boot_section, .boot_start, .lpm_word_addr, .lpm_byte_hi,
    .flash_erase_start, .flash_write_start, .flash_page);
